// >>> hdl/pmo_pkg.sv
// Constants, field layouts and state types of the power-management option registers
//   Function
// - Enabled detector sets the read-only supply-drop flag, bit 7 of status one.
// - Writing one to the drop acknowledge clears the flag; zero does nothing; reads zero.
// - With the drop interrupt enable set, request an interrupt while the flag is set.
// - With reset enable and detector enabled, a set flag forces a system reset.
// - Stop enable keeps detection running in stop mode; zero disables it there.
// - Detector enable off makes flag, reset and stop behaviour of detector inactive.
// - Bit 0 of status one switches the internal reference buffer on or off.
// - Warning flag sets when supply is below warning level and stays set afterwards.
// - Warning acknowledge clears the warning flag only once the warning is gone.
// - Drop trip select takes only the first write after power-on; others keep it.
// - Warning trip select picks low or high; power-on clears it, other resets keep it.
// - Recovery flag reads one right after leaving partial power down stop.
// - Writing one to the recovery acknowledge, bit 2, clears the recovery flag.
// - Deep stop select writable once per reset; zero retained logic, one power down.
// - Watchdog clock select writable once per reset; picks 1 kHz clock or bus clock.
// - Timer routing picks one shared external clock or three separate timer clocks.
package pmo_pkg;

  // ----------------------------------------
  // Register byte offsets
  // ----------------------------------------
  localparam logic [11:0] PMO_PS1_OFS = 12'h000;
  localparam logic [11:0] PMO_PS2_OFS = 12'h004;
  localparam logic [11:0] PMO_OPT2_OFS = 12'h008;
  localparam logic [11:0] PMO_ISTAT_OFS = 12'h00C;
  localparam logic [11:0] PMO_IMASK_OFS = 12'h010;

  // ----------------------------------------
  // Field positions
  // ----------------------------------------
  localparam int PMO_PS1_FLAG = 7;
  localparam int PMO_PS1_ACK = 6;
  localparam int PMO_PS1_IRQEN = 5;
  localparam int PMO_PS1_RSTEN = 4;
  localparam int PMO_PS1_STOPEN = 3;
  localparam int PMO_PS1_DETEN = 2;
  localparam int PMO_PS1_RSVD = 1;
  localparam int PMO_PS1_REFBUF = 0;
  localparam int PMO_PS2_WFLAG = 7;
  localparam int PMO_PS2_WACK = 6;
  localparam int PMO_PS2_DTRIP = 5;
  localparam int PMO_PS2_WTRIP = 4;
  localparam int PMO_PS2_RFLAG = 3;
  localparam int PMO_PS2_RACK = 2;
  localparam int PMO_PS2_DSEL = 0;
  localparam int PMO_OPT2_WDOG = 7;
  localparam int PMO_OPT2_ROUTE = 3;
  localparam int PMO_EV_DROP = 0;
  localparam int PMO_EV_WARN = 1;
  localparam int PMO_EV_RECOV = 2;
  localparam int PMO_EV_N = 3;

  // ----------------------------------------
  // State types and reset values
  // ----------------------------------------
  typedef struct packed {
    logic [2:0] drop_sync;
    logic [2:0] warn_sync;
    logic drop_lvl;
    logic warn_lvl;
    logic supply_drop_flag;
    logic supply_drop_irq_en;
    logic supply_drop_reset_en;
    logic supply_drop_stop_en;
    logic supply_drop_detect_en;
    logic reference_buffer_en;
    logic supply_warning_flag;
    logic deep_stop_recovery_flag;
    logic deep_stop_select;
    logic deep_stop_lock;
    logic watchdog_clock_select;
    logic watchdog_lock;
    logic timer_clock_routing;
    logic [PMO_EV_N-1:0] irq_stat;
    logic [PMO_EV_N-1:0] irq_mask;
    logic [31:0] rdata;
  } pmo_state_s;

  typedef struct packed {
    logic drop_trip_select;
    logic drop_trip_lock;
    logic warning_trip_select;
  } pmo_por_s;

  localparam pmo_state_s PMO_STATE_RST = '0;
  localparam pmo_por_s PMO_POR_RST = '0;

endpackage

// >>> hdl/pmo_regs.sv
// Power-management status, control and option registers with an APB slave
`timescale 1ns/1ns
module pmo_regs
  import pmo_pkg::*;
#(
  parameter int ADDR_W = 12
) (
  // Clock, resets and clock enable
  input wire logic pclk,
  input wire logic presetn,
  input wire logic power_on_rst_n,
  input wire logic clk_en,
  // APB slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [ADDR_W-1:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [3:0] pstrb,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // Comparators and power controller
  input wire logic supply_drop_raw,
  input wire logic supply_warning_raw,
  input wire logic stop_mode,
  input wire logic deep_stop_exit,
  // Supply-drop and warning detector controls
  output logic supply_drop_irq,
  output logic system_reset_req,
  output logic drop_detector_on,
  output logic reference_buffer_en,
  output logic drop_trip_select,
  output logic warning_trip_select,
  // Stop mode, watchdog and timer options
  output logic deep_stop_select,
  output logic watchdog_clock_select,
  output logic timer_clock_routing,
  // Summary interrupt
  output logic irq
);

  // ----------------------------------------
  // Parameter check
  // ----------------------------------------
  if (ADDR_W < 5 || ADDR_W > 32) begin : g_addr_chk
    $error("ADDR_W must lie between 5 and 32");
  end

  // ----------------------------------------
  // State
  // ----------------------------------------
  pmo_state_s st_reg;
  pmo_state_s st_next;
  pmo_por_s por_reg;
  pmo_por_s por_next;

  // ----------------------------------------
  // Bus decode
  // ----------------------------------------
  logic acc;
  logic setup;
  logic hit_ps1;
  logic hit_ps2;
  logic hit_opt2;
  logic hit_istat;
  logic hit_imask;
  logic mapped;
  logic wr_en;
  logic [7:0] wd;
  logic [31:0] rd_val;
  logic det_ok;
  logic drop_set;
  logic warn_set;
  logic [PMO_EV_N-1:0] ev;

  assign acc = psel & penable;
  assign setup = psel & ~penable;
  assign hit_ps1 = paddr == ADDR_W'(PMO_PS1_OFS);
  assign hit_ps2 = paddr == ADDR_W'(PMO_PS2_OFS);
  assign hit_opt2 = paddr == ADDR_W'(PMO_OPT2_OFS);
  assign hit_istat = paddr == ADDR_W'(PMO_ISTAT_OFS);
  assign hit_imask = paddr == ADDR_W'(PMO_IMASK_OFS);
  assign mapped = hit_ps1 | hit_ps2 | hit_opt2 | hit_istat | hit_imask;
  // Registers are one byte wide, so only lane 0 carries a write
  assign wr_en = acc & pwrite & clk_en & pstrb[0] & mapped;
  assign wd = pwdata[7:0];

  // Zero wait states; a frozen clock enable stalls the access phase
  assign pready = clk_en;
  assign pslverr = acc & ~mapped;
  assign prdata = st_reg.rdata;

  // ----------------------------------------
  // Detector qualification and events
  // ----------------------------------------
  // Stop mode gates detection unless the stop enable keeps it alive
  assign det_ok = st_reg.supply_drop_detect_en & (~stop_mode | st_reg.supply_drop_stop_en);
  assign drop_set = det_ok & st_reg.drop_lvl;
  // A warning level held across reset sets the flag on the first filtered sample
  assign warn_set = st_reg.warn_lvl;

  always_comb begin
    ev = '0;
    ev[PMO_EV_DROP] = drop_set;
    ev[PMO_EV_WARN] = warn_set;
    ev[PMO_EV_RECOV] = deep_stop_exit;
  end

  // ----------------------------------------
  // Read multiplexer
  // ----------------------------------------
  always_comb begin
    rd_val = '0;
    if (hit_ps1) begin
      rd_val[PMO_PS1_FLAG] = st_reg.supply_drop_flag;
      rd_val[PMO_PS1_IRQEN] = st_reg.supply_drop_irq_en;
      rd_val[PMO_PS1_RSTEN] = st_reg.supply_drop_reset_en;
      rd_val[PMO_PS1_STOPEN] = st_reg.supply_drop_stop_en;
      rd_val[PMO_PS1_DETEN] = st_reg.supply_drop_detect_en;
      rd_val[PMO_PS1_REFBUF] = st_reg.reference_buffer_en;
    end else if (hit_ps2) begin
      // Acknowledge bits and bit 1 stay at zero
      rd_val[PMO_PS2_WFLAG] = st_reg.supply_warning_flag;
      rd_val[PMO_PS2_DTRIP] = por_reg.drop_trip_select;
      rd_val[PMO_PS2_WTRIP] = por_reg.warning_trip_select;
      rd_val[PMO_PS2_RFLAG] = st_reg.deep_stop_recovery_flag;
      rd_val[PMO_PS2_DSEL] = st_reg.deep_stop_select;
    end else if (hit_opt2) begin
      rd_val[PMO_OPT2_WDOG] = st_reg.watchdog_clock_select;
      rd_val[PMO_OPT2_ROUTE] = st_reg.timer_clock_routing;
    end else if (hit_istat) begin
      rd_val[PMO_EV_N-1:0] = st_reg.irq_stat;
    end else if (hit_imask) begin
      rd_val[PMO_EV_N-1:0] = st_reg.irq_mask;
    end
  end

  // ----------------------------------------
  // Next state
  // ----------------------------------------
  always_comb begin
    st_next = st_reg;
    por_next = por_reg;
    if (clk_en) begin
      // Three-stage pin synchronisers; a level counts once stages two and three agree
      st_next.drop_sync = {st_reg.drop_sync[1:0], supply_drop_raw};
      st_next.warn_sync = {st_reg.warn_sync[1:0], supply_warning_raw};
      if (st_reg.drop_sync[1] == st_reg.drop_sync[2]) begin
        st_next.drop_lvl = st_reg.drop_sync[2];
      end
      if (st_reg.warn_sync[1] == st_reg.warn_sync[2]) begin
        st_next.warn_lvl = st_reg.warn_sync[2];
      end

      // Status one: reserved bit 1 is never stored
      if (wr_en && hit_ps1) begin
        st_next.supply_drop_irq_en = wd[PMO_PS1_IRQEN];
        st_next.supply_drop_reset_en = wd[PMO_PS1_RSTEN];
        st_next.supply_drop_stop_en = wd[PMO_PS1_STOPEN];
        st_next.supply_drop_detect_en = wd[PMO_PS1_DETEN];
        st_next.reference_buffer_en = wd[PMO_PS1_REFBUF];
        if (wd[PMO_PS1_ACK]) begin
          st_next.supply_drop_flag = 1'b0;
        end
      end
      // Set after clear so a same-cycle event survives the acknowledge
      if (drop_set) begin
        st_next.supply_drop_flag = 1'b1;
      end

      // Status two
      if (wr_en && hit_ps2) begin
        if (wd[PMO_PS2_WACK] && !st_reg.warn_lvl) begin
          st_next.supply_warning_flag = 1'b0;
        end
        if (!por_reg.drop_trip_lock) begin
          por_next.drop_trip_select = wd[PMO_PS2_DTRIP];
          por_next.drop_trip_lock = 1'b1;
        end
        por_next.warning_trip_select = wd[PMO_PS2_WTRIP];
        if (wd[PMO_PS2_RACK]) begin
          st_next.deep_stop_recovery_flag = 1'b0;
        end
        if (!st_reg.deep_stop_lock) begin
          st_next.deep_stop_select = wd[PMO_PS2_DSEL];
          st_next.deep_stop_lock = 1'b1;
        end
      end
      if (warn_set) begin
        st_next.supply_warning_flag = 1'b1;
      end
      if (deep_stop_exit) begin
        st_next.deep_stop_recovery_flag = 1'b1;
      end

      // System options
      if (wr_en && hit_opt2) begin
        if (!st_reg.watchdog_lock) begin
          st_next.watchdog_clock_select = wd[PMO_OPT2_WDOG];
          st_next.watchdog_lock = 1'b1;
        end
        st_next.timer_clock_routing = wd[PMO_OPT2_ROUTE];
      end

      // Interrupt status: write one to clear, events win
      if (wr_en && hit_istat) begin
        st_next.irq_stat = st_reg.irq_stat & ~wd[PMO_EV_N-1:0];
      end
      st_next.irq_stat = st_next.irq_stat | ev;
      if (wr_en && hit_imask) begin
        st_next.irq_mask = wd[PMO_EV_N-1:0];
      end

      // Read data is caught in the setup cycle and shown in the access phase
      if (setup) begin
        st_next.rdata = rd_val;
      end
    end
  end

  // ----------------------------------------
  // Registers
  // ----------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st_reg <= PMO_STATE_RST;
    end else begin
      st_reg <= st_next;
    end
  end

  // Trip selects survive every reset except power-on
  always_ff @(posedge pclk or negedge power_on_rst_n) begin
    if (!power_on_rst_n) begin
      por_reg <= PMO_POR_RST;
    end else begin
      por_reg <= por_next;
    end
  end

  // ----------------------------------------
  // Outputs
  // ----------------------------------------
  assign supply_drop_irq = st_reg.supply_drop_flag & st_reg.supply_drop_irq_en;
  // Level request; the reset it causes clears the flag and so ends it
  assign system_reset_req = st_reg.supply_drop_flag & st_reg.supply_drop_reset_en
                            & st_reg.supply_drop_detect_en;
  assign drop_detector_on = det_ok;
  assign reference_buffer_en = st_reg.reference_buffer_en;
  assign drop_trip_select = por_reg.drop_trip_select;
  assign warning_trip_select = por_reg.warning_trip_select;
  assign deep_stop_select = st_reg.deep_stop_select;
  assign watchdog_clock_select = st_reg.watchdog_clock_select;
  assign timer_clock_routing = st_reg.timer_clock_routing;
  assign irq = |(st_reg.irq_stat & st_reg.irq_mask);

  // ----------------------------------------
  // Assertions
  // ----------------------------------------
  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn || !power_on_rst_n);

  drop_set_a: assert property (clk_en && drop_set |=> st_reg.supply_drop_flag)
    else $error("drop flag not set by qualified event");

  drop_ack_a: assert property (wr_en && hit_ps1 && wd[PMO_PS1_ACK] && !drop_set
    |=> !st_reg.supply_drop_flag)
    else $error("drop acknowledge did not clear flag");

  drop_irq_a: assert property ($rose(st_reg.supply_drop_flag) && st_reg.supply_drop_irq_en
    |-> supply_drop_irq)
    else $error("drop interrupt missing");

  drop_rst_a: assert property (system_reset_req |-> st_reg.supply_drop_flag
    && st_reg.supply_drop_detect_en)
    else $error("system reset without enabled flag");

  stop_gate_a: assert property (clk_en && stop_mode && !st_reg.supply_drop_stop_en
    && !st_reg.supply_drop_flag |=> !st_reg.supply_drop_flag)
    else $error("drop flag set during stop with detection off");

  det_off_a: assert property (!st_reg.supply_drop_detect_en |=> !$rose(st_reg.supply_drop_flag)
    && !system_reset_req)
    else $error("detector acted while disabled");

  refbuf_a: assert property (wr_en && hit_ps1 ##1 1'b1 |-> reference_buffer_en
    == $past(wd[PMO_PS1_REFBUF]))
    else $error("reference buffer enable not written");

  warn_hold_a: assert property (st_reg.supply_warning_flag && !(wr_en && hit_ps2)
    |=> st_reg.supply_warning_flag)
    else $error("warning flag dropped without acknowledge");

  warn_ack_a: assert property (wr_en && hit_ps2 && st_reg.warn_lvl
    |=> st_reg.supply_warning_flag)
    else $error("warning flag cleared while warning present");

  trip_once_a: assert property (por_reg.drop_trip_lock |=> $stable(por_reg.drop_trip_select))
    else $error("drop trip select changed after first write");

  recov_a: assert property (clk_en && deep_stop_exit |=> st_reg.deep_stop_recovery_flag [*2]
    or ##1 (wr_en && hit_ps2))
    else $error("recovery flag not held after deep stop exit");

  recov_ack_a: assert property (wr_en && hit_ps2 && wd[PMO_PS2_RACK] && !deep_stop_exit
    |=> !st_reg.deep_stop_recovery_flag)
    else $error("recovery acknowledge did not clear flag");

  dsel_once_a: assert property (st_reg.deep_stop_lock |=> $stable(deep_stop_select))
    else $error("deep stop select changed after first write");

  wdog_once_a: assert property (st_reg.watchdog_lock |=> $stable(watchdog_clock_select))
    else $error("watchdog clock select changed after first write");

  ps2_zero_a: assert property (acc && hit_ps2 |-> prdata[31:8] == 24'h000000
    && !prdata[PMO_PS2_WACK] && !prdata[PMO_PS2_RACK] && !prdata[1])
    else $error("unused status two bits read non-zero");

endmodule

// >>> dv/tb_top.sv
// Self-checking testbench for the power-management option registers
`timescale 1ns/1ns
module tb_top
  import pmo_pkg::*;
;
  logic pclk, presetn, power_on_rst_n, clk_en;
  logic psel, penable, pwrite;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  logic [3:0] pstrb;
  logic pready, pslverr, err;
  logic supply_drop_raw, supply_warning_raw, stop_mode, deep_stop_exit;
  logic supply_drop_irq, system_reset_req, drop_detector_on, reference_buffer_en;
  logic drop_trip_select, warning_trip_select, deep_stop_select;
  logic watchdog_clock_select, timer_clock_routing, irq;
  int bad_count, total_checks;

  pmo_regs #(.ADDR_W(12)) dut_u (
    .pclk(pclk), .presetn(presetn), .power_on_rst_n(power_on_rst_n), .clk_en(clk_en),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .pstrb(pstrb), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .supply_drop_raw(supply_drop_raw), .supply_warning_raw(supply_warning_raw),
    .stop_mode(stop_mode), .deep_stop_exit(deep_stop_exit),
    .supply_drop_irq(supply_drop_irq), .system_reset_req(system_reset_req),
    .drop_detector_on(drop_detector_on), .reference_buffer_en(reference_buffer_en),
    .drop_trip_select(drop_trip_select), .warning_trip_select(warning_trip_select),
    .deep_stop_select(deep_stop_select), .watchdog_clock_select(watchdog_clock_select),
    .timer_clock_routing(timer_clock_routing), .irq(irq)
  );

  // ----------------------------------------
  // Clock, checking and bus tasks
  // ----------------------------------------
  initial begin
    pclk = 1'b0;
    forever #5 pclk = ~pclk;
  end

  task automatic finish_test();
    $display("Checks made: %0d, mismatches: %0d", total_checks, bad_count);
    if (bad_count == 0 && total_checks > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    total_checks++;
    if (seen !== exp) begin
      bad_count++;
      $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  // Request held until pready is seen high at a rising edge; data taken there
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    if (pready !== 1'b1) bad_count++;
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    #1;
  endtask

  task automatic wr(input logic [11:0] a, input logic [7:0] d);
    apb(1'b1, a, {24'h0, d});
  endtask

  task automatic rdc(input logic [11:0] a, input logic [7:0] e);
    apb(1'b0, a, 32'h0);
    chk(rd, {24'h0, e});
  endtask

  // Comparator inputs pass a three-stage synchroniser before the flags see them
  task automatic wait_sync();
    repeat (6) @(posedge pclk);
    #1;
  endtask

  task automatic do_reset(input logic por);
    @(posedge pclk);
    presetn <= 1'b0;
    power_on_rst_n <= ~por;
    repeat (12) @(posedge pclk);
    presetn <= 1'b1;
    power_on_rst_n <= 1'b1;
    @(posedge pclk);
    #1;
  endtask

  // ----------------------------------------
  // Watchdog
  // ----------------------------------------
  initial begin
    #100000;
    bad_count++;
    finish_test();
  end

  // ----------------------------------------
  // Test sequence
  // ----------------------------------------
  initial begin
    presetn = 1'b0;
    power_on_rst_n = 1'b0;
    clk_en = 1'b1;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 12'h000;
    pwdata = 32'h0;
    pstrb = 4'h1;
    supply_drop_raw = 1'b0;
    supply_warning_raw = 1'b0;
    stop_mode = 1'b0;
    deep_stop_exit = 1'b0;
    bad_count = 0;
    total_checks = 0;
    do_reset(1'b1);
    rdc(PMO_PS1_OFS, 8'h00);
    rdc(PMO_PS2_OFS, 8'h00);
    rdc(PMO_OPT2_OFS, 8'h00);
    apb(1'b1, 12'h014, 32'h0000_00FF);
    chk(err, 1'b1);
    apb(1'b0, 12'h014, 32'h0);
    chk(rd, 32'h0);
    // Status two: write-once fields, unused bit 1 and warning flag
    wr(PMO_PS2_OFS, 8'h33);
    rdc(PMO_PS2_OFS, 8'h31);
    chk(deep_stop_select, 1'b1);
    wr(PMO_PS2_OFS, 8'h00);
    rdc(PMO_PS2_OFS, 8'h21);
    chk(drop_trip_select, 1'b1);
    chk(warning_trip_select, 1'b0);
    supply_warning_raw <= 1'b1;
    wait_sync();
    rdc(PMO_PS2_OFS, 8'hA1);
    rdc(PMO_ISTAT_OFS, 8'h02);
    chk(irq, 1'b0);
    wr(PMO_IMASK_OFS, 8'h02);
    chk(irq, 1'b1);
    wr(PMO_PS2_OFS, 8'h40);
    rdc(PMO_PS2_OFS, 8'hA1);
    supply_warning_raw <= 1'b0;
    wait_sync();
    rdc(PMO_PS2_OFS, 8'hA1);
    wr(PMO_PS2_OFS, 8'h50);
    rdc(PMO_PS2_OFS, 8'h31);
    wr(PMO_ISTAT_OFS, 8'h02);
    rdc(PMO_ISTAT_OFS, 8'h00);
    chk(irq, 1'b0);
    // Ordinary reset keeps both trip selects and reopens the deep stop select
    do_reset(1'b0);
    rdc(PMO_PS2_OFS, 8'h30);
    wr(PMO_PS2_OFS, 8'h01);
    rdc(PMO_PS2_OFS, 8'h21);
    do_reset(1'b1);
    rdc(PMO_PS2_OFS, 8'h00);
    @(posedge pclk);
    deep_stop_exit <= 1'b1;
    @(posedge pclk);
    deep_stop_exit <= 1'b0;
    rdc(PMO_PS2_OFS, 8'h08);
    wr(PMO_PS2_OFS, 8'h04);
    rdc(PMO_PS2_OFS, 8'h00);
    // Options two
    wr(PMO_OPT2_OFS, 8'h88);
    rdc(PMO_OPT2_OFS, 8'h88);
    chk(watchdog_clock_select, 1'b1);
    chk(timer_clock_routing, 1'b1);
    wr(PMO_OPT2_OFS, 8'h00);
    rdc(PMO_OPT2_OFS, 8'h80);
    chk(timer_clock_routing, 1'b0);
    // Status one: supply-drop detector; bit 1 always written as zero
    wr(PMO_PS1_OFS, 8'h3D);
    rdc(PMO_PS1_OFS, 8'h3D);
    chk(reference_buffer_en, 1'b1);
    chk(drop_detector_on, 1'b1);
    supply_drop_raw <= 1'b1;
    wait_sync();
    rdc(PMO_PS1_OFS, 8'hBD);
    chk(supply_drop_irq, 1'b1);
    chk(system_reset_req, 1'b1);
    // Recovery event from the deep stop exit is still pending beside the drop event
    rdc(PMO_ISTAT_OFS, 8'h05);
    supply_drop_raw <= 1'b0;
    wait_sync();
    wr(PMO_PS1_OFS, 8'h7D);
    rdc(PMO_PS1_OFS, 8'h3D);
    chk(supply_drop_irq, 1'b0);
    chk(system_reset_req, 1'b0);
    wr(PMO_PS1_OFS, 8'h1C);
    supply_drop_raw <= 1'b1;
    wait_sync();
    chk(supply_drop_irq, 1'b0);
    chk(system_reset_req, 1'b1);
    supply_drop_raw <= 1'b0;
    wait_sync();
    wr(PMO_PS1_OFS, 8'h5C);
    rdc(PMO_PS1_OFS, 8'h1C);
    wr(PMO_PS1_OFS, 8'h30);
    chk(drop_detector_on, 1'b0);
    supply_drop_raw <= 1'b1;
    wait_sync();
    rdc(PMO_PS1_OFS, 8'h30);
    chk(system_reset_req, 1'b0);
    supply_drop_raw <= 1'b0;
    wait_sync();
    wr(PMO_PS1_OFS, 8'h04);
    @(posedge pclk);
    stop_mode <= 1'b1;
    #1;
    chk(drop_detector_on, 1'b0);
    wr(PMO_PS1_OFS, 8'h0C);
    chk(drop_detector_on, 1'b1);
    @(posedge pclk);
    stop_mode <= 1'b0;
    finish_test();
  end
endmodule
